// ==== include/dfa_cfg.svh ====
`ifndef DFA_CFG_SVH
`define DFA_CFG_SVH

// register offsets (byte addresses)
`define DFA_OFS_CTRL 8'h00
`define DFA_OFS_STAT 8'h04
`define DFA_OFS_SRC 8'h08
`define DFA_OFS_DST 8'h0c
`define DFA_OFS_TCNT 8'h10
`define DFA_OFS_BSZ 8'h14
`define DFA_OFS_BCNT 8'h18

// control register bit positions
`define DFA_B_XE 0
`define DFA_B_IE 1
`define DFA_B_ME 2
`define DFA_B_FAE 3
`define DFA_B_BLK 4
`define DFA_B_BAS 5
`define DFA_B_SZ 6
`define DFA_B_SDIR 7
`define DFA_B_SEN 8
`define DFA_B_DDIR 9
`define DFA_B_DEN 10
`define DFA_B_AUTO 11
`define DFA_B_BURST 12
`define DFA_F_SEL_HI 19
`define DFA_F_SEL_LO 16

// status register bit positions
`define DFA_S_BUSY 0
`define DFA_S_END 1

// activation source select codes
`define DFA_SEL_EXT 4'h0
`define DFA_SEL_TXC 4'h1
`define DFA_SEL_RXC 4'h2
`define DFA_SEL_TMR0 4'h3
`define DFA_TMR_CH 6

// widths and special values
`define DFA_AW 24
`define DFA_DW 16
`define DFA_CNT_ONE 16'h0001
`define DFA_BSZ_ONE 8'h01
`define DFA_BSZ_FULL 9'h100
`define DFA_INT_BASE 24'hffc000

`endif

// ==== include/dfa_pkg.sv ====
`include "dfa_cfg.svh"

package dfa_pkg;

    typedef enum logic [2:0] {
        DFA_IDLE,
        DFA_ARB,
        DFA_RD,
        DFA_WR,
        DFA_DEAD
    } dfa_state_e;

    // one access toward the bus controller
    typedef struct packed {
        logic req;
        logic we;
        logic word;
        logic ext;
        logic [`DFA_AW-1:0] addr;
        logic [`DFA_DW-1:0] wdata;
    } dfa_acc_s;

    typedef struct packed {
        dfa_state_e st;
        logic [31:0] ctrl;
        logic end_flag;
        logic [`DFA_AW-1:0] src;
        logic [`DFA_AW-1:0] dst;
        logic [15:0] tcnt;
        logic [7:0] bhold;
        logic [7:0] bcnt;
        logic [15:0] blkcnt;
        logic [`DFA_DW-1:0] data;
        logic req_pend;
        logic bus_req;
        dfa_acc_s acc;
        logic irq;
        logic wb_ack;
        logic [31:0] wb_dat;
    } dfa_regs_s;

endpackage

// ==== rtl/dfa_engine.sv ====
`timescale 1ns/10ps
`include "dfa_cfg.svh"
// Behaviour
// - full-addr on, block off: normal, A->B
// - 24-bit addresses step by 1/2 or hold
// - count down per transfer; zero ends, clears enable
// - end with irq enable raises interrupt
// - start count zero means 65536 transfers
// - external or auto request; auto runs whole count
// - cycle steal releases bus after each transfer
// - auto-request burst holds bus until transfer ends or nmi
// - full-addr and block bits set: block mode, block per request
// - block area bit picks source or destination
// - size counter bursts to zero then reloads
// - block-area address restored at reload
// - block counter zero ends, clears enable, irq
// - block mode takes ext, serial, timer events
// - read then write, bus held between
// - accesses use bus controller width and states
// - internal accesses keep address off external bus
// - one dead state after final write
// - nmi never cuts a running block
module dfa_engine #(
    parameter logic [`DFA_AW-1:0] INT_BASE = `DFA_INT_BASE
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // activation sources
    input wire logic ext_req,
    input wire logic serial_tx_done,
    input wire logic serial_rx_done,
    input wire logic [`DFA_TMR_CH-1:0] timer_evt,
    input wire logic nmi,
    // bus ownership
    output logic bus_req,
    input wire logic bus_gnt,
    // access port toward bus controller
    output dfa_pkg::dfa_acc_s acc_o,
    input wire logic acc_ack,
    input wire logic [`DFA_DW-1:0] acc_rdata,
    // transfer end interrupt request
    output logic end_irq
);

    dfa_pkg::dfa_regs_s s_r;
    dfa_pkg::dfa_regs_s s_nxt;

    function automatic logic [31:0] dfa_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // signed step added to an address after one transfer
    function automatic logic [`DFA_AW-1:0] dfa_step(
        input logic [`DFA_AW-1:0] a,
        input logic en,
        input logic dir,
        input logic word
    );
        logic [`DFA_AW-1:0] d;
        d = word ? `DFA_AW'(2) : `DFA_AW'(1);
        if (!en) begin
            return a;
        end
        return dir ? a - d : a + d;
    endfunction

    logic run;
    logic blk;
    logic sz;
    logic evt;
    logic src_ok;
    logic go;
    logic [3:0] sel;
    logic [8:0] blk_m;
    logic [`DFA_AW-1:0] span;
    logic [`DFA_AW-1:0] nsrc;
    logic [`DFA_AW-1:0] ndst;
    logic wb_hit;
    logic [31:0] rd_v;

    always_comb begin
        s_nxt = s_r;
        run = s_r.ctrl[`DFA_B_XE] & s_r.ctrl[`DFA_B_ME] & s_r.ctrl[`DFA_B_FAE];
        blk = s_r.ctrl[`DFA_B_BLK];
        sz = s_r.ctrl[`DFA_B_SZ];
        sel = s_r.ctrl[`DFA_F_SEL_HI:`DFA_F_SEL_LO];
        // activation source mux
        evt = 1'b0;
        case (sel)
            `DFA_SEL_EXT: evt = ext_req;
            `DFA_SEL_TXC: evt = serial_tx_done;
            `DFA_SEL_RXC: evt = serial_rx_done;
            default: begin
                for (int i = 0; i < `DFA_TMR_CH; i++) begin
                    if (sel == `DFA_SEL_TMR0 + 4'(i)) begin
                        evt = timer_evt[i];
                    end
                end
            end
        endcase
        // normal mode takes only the external pin
        src_ok = blk | (sel == `DFA_SEL_EXT);
        go = run & ((s_r.ctrl[`DFA_B_AUTO] & ~blk) | s_r.req_pend);
        // block size 0 stands for 256
        blk_m = (s_r.bhold == 8'h00) ? `DFA_BSZ_FULL : {1'b0, s_r.bhold};
        span = sz ? `DFA_AW'({blk_m, 1'b0}) : `DFA_AW'(blk_m);
        nsrc = dfa_step(s_r.src, s_r.ctrl[`DFA_B_SEN], s_r.ctrl[`DFA_B_SDIR], sz);
        ndst = dfa_step(s_r.dst, s_r.ctrl[`DFA_B_DEN], s_r.ctrl[`DFA_B_DDIR], sz);

        // wishbone slave: ack one cycle after strobe, dropped next
        s_nxt.wb_ack = 1'b0;
        wb_hit = wb_cyc_i & wb_stb_i & ~s_r.wb_ack;
        rd_v = 32'h0000_0000;
        case (wb_adr_i)
            `DFA_OFS_CTRL: rd_v = s_r.ctrl;
            `DFA_OFS_STAT: begin
                rd_v[`DFA_S_BUSY] = (s_r.st != dfa_pkg::DFA_IDLE);
                rd_v[`DFA_S_END] = s_r.end_flag;
            end
            `DFA_OFS_SRC: rd_v = {8'h00, s_r.src};
            `DFA_OFS_DST: rd_v = {8'h00, s_r.dst};
            `DFA_OFS_TCNT: rd_v = {16'h0000, s_r.tcnt};
            `DFA_OFS_BSZ: rd_v = {16'h0000, s_r.bhold, s_r.bcnt};
            `DFA_OFS_BCNT: rd_v = {16'h0000, s_r.blkcnt};
            default: rd_v = 32'h0000_0000;
        endcase
        if (wb_hit) begin
            s_nxt.wb_ack = 1'b1;
            s_nxt.wb_dat = wb_we_i ? 32'h0000_0000 : rd_v;
            if (wb_we_i) begin
                case (wb_adr_i)
                    `DFA_OFS_CTRL: s_nxt.ctrl = dfa_merge(s_r.ctrl, wb_dat_i, wb_sel_i);
                    `DFA_OFS_STAT: begin
                        if (wb_sel_i[0] & wb_dat_i[`DFA_S_END]) begin
                            s_nxt.end_flag = 1'b0;
                        end
                    end
                    `DFA_OFS_SRC: s_nxt.src = 24'(dfa_merge({8'h00, s_r.src}, wb_dat_i,
                        wb_sel_i));
                    `DFA_OFS_DST: s_nxt.dst = 24'(dfa_merge({8'h00, s_r.dst}, wb_dat_i,
                        wb_sel_i));
                    `DFA_OFS_TCNT: s_nxt.tcnt = 16'(dfa_merge({16'h0000, s_r.tcnt},
                        wb_dat_i, wb_sel_i));
                    `DFA_OFS_BSZ: {s_nxt.bhold, s_nxt.bcnt} = 16'(dfa_merge(
                        {16'h0000, s_r.bhold, s_r.bcnt}, wb_dat_i, wb_sel_i));
                    `DFA_OFS_BCNT: s_nxt.blkcnt = 16'(dfa_merge({16'h0000, s_r.blkcnt},
                        wb_dat_i, wb_sel_i));
                    default: ;
                endcase
            end
        end

        // nmi stops further activations and ends an auto burst; a started block runs out
        if (nmi) begin
            s_nxt.ctrl[`DFA_B_ME] = 1'b0;
        end

        // transfer engine; its updates override a racing register write
        case (s_r.st)
            dfa_pkg::DFA_IDLE: begin
                s_nxt.bus_req = 1'b0;
                if (go) begin
                    s_nxt.req_pend = 1'b0;
                    s_nxt.bus_req = 1'b1;
                    s_nxt.st = dfa_pkg::DFA_ARB;
                end
            end
            dfa_pkg::DFA_ARB: begin
                if (bus_gnt) begin
                    s_nxt.acc.req = 1'b1;
                    s_nxt.acc.we = 1'b0;
                    s_nxt.acc.word = sz;
                    s_nxt.acc.addr = s_r.src;
                    s_nxt.acc.ext = (s_r.src < INT_BASE);
                    s_nxt.st = dfa_pkg::DFA_RD;
                end
            end
            dfa_pkg::DFA_RD: begin
                if (acc_ack) begin
                    // write follows at once, bus still held
                    s_nxt.data = acc_rdata;
                    s_nxt.acc.we = 1'b1;
                    s_nxt.acc.addr = s_r.dst;
                    s_nxt.acc.wdata = acc_rdata;
                    s_nxt.acc.ext = (s_r.dst < INT_BASE);
                    s_nxt.st = dfa_pkg::DFA_WR;
                end
            end
            dfa_pkg::DFA_WR: begin
                if (acc_ack) begin
                    s_nxt.acc.req = 1'b0;
                    s_nxt.acc.we = 1'b0;
                    s_nxt.src = nsrc;
                    s_nxt.dst = ndst;
                    if (!blk) begin
                        s_nxt.tcnt = s_r.tcnt - 16'h0001;
                        if (s_r.tcnt == `DFA_CNT_ONE) begin
                            s_nxt.ctrl[`DFA_B_XE] = 1'b0;
                            s_nxt.end_flag = 1'b1;
                            s_nxt.st = dfa_pkg::DFA_DEAD;
                        end else if (s_r.ctrl[`DFA_B_AUTO] & s_r.ctrl[`DFA_B_BURST]
                            & s_r.ctrl[`DFA_B_ME]) begin
                            s_nxt.acc.req = 1'b1;
                            s_nxt.acc.addr = nsrc;
                            s_nxt.acc.ext = (nsrc < INT_BASE);
                            s_nxt.st = dfa_pkg::DFA_RD;
                        end else begin
                            s_nxt.bus_req = 1'b0;
                            s_nxt.st = dfa_pkg::DFA_IDLE;
                        end
                    end else begin
                        s_nxt.bcnt = s_r.bcnt - 8'h01;
                        if (s_r.bcnt == `DFA_BSZ_ONE) begin
                            s_nxt.bcnt = s_r.bhold;
                            if (s_r.ctrl[`DFA_B_BAS]) begin
                                if (s_r.ctrl[`DFA_B_SEN]) begin
                                    s_nxt.src = s_r.ctrl[`DFA_B_SDIR] ? nsrc + span
                                        : nsrc - span;
                                end
                            end else if (s_r.ctrl[`DFA_B_DEN]) begin
                                s_nxt.dst = s_r.ctrl[`DFA_B_DDIR] ? ndst + span
                                    : ndst - span;
                            end
                            s_nxt.blkcnt = s_r.blkcnt - 16'h0001;
                            if (s_r.blkcnt == `DFA_CNT_ONE) begin
                                s_nxt.ctrl[`DFA_B_XE] = 1'b0;
                                s_nxt.end_flag = 1'b1;
                            end
                            s_nxt.st = dfa_pkg::DFA_DEAD;
                        end else begin
                            // block keeps the bus until its last transfer
                            s_nxt.acc.req = 1'b1;
                            s_nxt.acc.addr = nsrc;
                            s_nxt.acc.ext = (nsrc < INT_BASE);
                            s_nxt.st = dfa_pkg::DFA_RD;
                        end
                    end
                end
            end
            dfa_pkg::DFA_DEAD: begin
                s_nxt.bus_req = 1'b0;
                s_nxt.st = dfa_pkg::DFA_IDLE;
            end
            default: begin
                s_nxt.st = dfa_pkg::DFA_IDLE;
            end
        endcase

        // capture after the clear so a same-cycle event survives
        if (evt & src_ok & ~(s_r.ctrl[`DFA_B_AUTO] & ~blk) & run) begin
            s_nxt.req_pend = 1'b1;
        end
        s_nxt.irq = s_nxt.end_flag & s_nxt.ctrl[`DFA_B_IE];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o = s_r.wb_dat;
    assign wb_ack_o = s_r.wb_ack;
    assign bus_req = s_r.bus_req;
    assign acc_o = s_r.acc;
    assign end_irq = s_r.irq;

endmodule

// ==== verification/dfa_engine_sva.sv ====
`timescale 1ns/10ps
module dfa_engine_sva #(
    parameter logic [23:0] INT_BASE = 24'hffc000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // watched ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic bus_req,
    input wire logic bus_gnt,
    input wire dfa_pkg::dfa_acc_s acc_o,
    input wire logic acc_ack,
    input wire logic end_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("wishbone request not answered");
    wb_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("wishbone ack longer than one cycle");
    wr_data_zero_a: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
        else $error("read data not zero on write");
    rd_then_wr_a: assert property (acc_o.req && !acc_o.we && acc_ack |=> acc_o.req && acc_o.we)
        else $error("read not followed by write");
    req_owned_a: assert property (acc_o.req |-> bus_req)
        else $error("access without bus ownership");
    req_stable_a: assert property (acc_o.req && !acc_ack |=> $stable(acc_o))
        else $error("access changed before ack");
    int_addr_a: assert property (acc_o.req |-> acc_o.ext == (acc_o.addr < INT_BASE))
        else $error("external flag wrong for address");
    grant_first_a: assert property ($rose(acc_o.req) |-> $past(bus_gnt))
        else $error("access started without grant");
    release_wr_a: assert property ($fell(bus_req) |->
        ($past(acc_ack) && $past(acc_o.we)) || !$past(acc_o.req))
        else $error("bus released inside a transfer");
    cover property (acc_o.req && acc_o.we && acc_ack);
    cover property ($rose(end_irq));
    cover property (acc_o.req && !acc_o.ext);
endmodule

// ==== verification/dfa_bus_model.sv ====
`timescale 1ns/10ps
module dfa_bus_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // engine side
    input wire logic bus_req,
    output logic bus_gnt,
    input wire dfa_pkg::dfa_acc_s acc_o,
    output logic acc_ack,
    output logic [15:0] acc_rdata,
    // wait states set by the bench
    input wire logic [3:0] lat
);
    logic [3:0] cnt;
    logic req_q;
    int wcnt;
    int gcnt;
    logic [23:0] last_wa;
    logic [15:0] last_wd;
    always_ff @(posedge core_clk) begin
        acc_ack <= 1'b0;
        // idle data lines wander so a stale value never looks valid
        acc_rdata <= ~acc_rdata;
        bus_gnt <= rst_n && bus_req;
        req_q <= bus_req;
        if (!rst_n) begin
            cnt <= 4'h0;
            wcnt <= 0;
            gcnt <= 0;
            acc_rdata <= 16'h0000;
        end else begin
            if (bus_req && !req_q) gcnt <= gcnt + 1;
            if (acc_ack && acc_o.we) begin
                wcnt <= wcnt + 1;
                last_wa <= acc_o.addr;
                last_wd <= acc_o.wdata;
            end
            if (acc_o.req && !acc_ack) begin
                cnt <= cnt + 4'h1;
                if (cnt == lat) begin
                    acc_ack <= 1'b1;
                    cnt <= 4'h0;
                    if (!acc_o.we) acc_rdata <= acc_o.addr[15:0] ^ 16'h5a5a;
                end
            end
        end
    end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/10ps
module tb;
    logic core_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, tx = 1'b0;
    logic nmi = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, lat = 4'h2;
    logic [31:0] dat = 32'h0, wb_dat_o, q;
    logic wb_ack_o, bus_req, bus_gnt, acc_ack, end_irq;
    logic [15:0] acc_rdata;
    dfa_pkg::dfa_acc_s acc_o;
    int err_total = 0, total_checks = 0;
    always #50 core_clk = ~core_clk;
    dfa_engine dfa_engine_i (.core_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .ext_req(1'b0),
        .serial_tx_done(tx), .serial_rx_done(1'b0), .timer_evt(6'h00), .nmi(nmi),
        .bus_req, .bus_gnt, .acc_o, .acc_ack, .acc_rdata, .end_irq);
    dfa_bus_model dfa_bus_model_i (.core_clk, .rst_n, .bus_req, .bus_gnt, .acc_o, .acc_ack,
        .acc_rdata, .lat);
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        @(posedge core_clk iff wb_ack_o === 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wbx(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic wait_wr(input int n);
        for (int k = 0; k < 400 && dfa_bus_model_i.wcnt < n; k++) @(posedge core_clk);
        if (dfa_bus_model_i.wcnt < n) begin
            err_total++;
            $display("Error at %0t: write count not reached", $time);
        end
    endtask
    task automatic regs_check;
        rd(8'h00, 32'h0);
        wbx(1'b1, 8'h08, 32'hffffffff);
        rd(8'h08, 32'h00ffffff);
        rd(8'h1c, 32'h0);
    endtask
    task automatic normal_steal;
        int w0 = dfa_bus_model_i.wcnt;
        int g0 = dfa_bus_model_i.gcnt;
        wbx(1'b1, 8'h08, 32'h001000);
        wbx(1'b1, 8'h0c, 32'hffc010);
        wbx(1'b1, 8'h10, 32'h3);
        wbx(1'b1, 8'h00, 32'h0d0f);
        wait_wr(w0 + 3);
        chk(dfa_bus_model_i.gcnt - g0, 3);
        rd(8'h08, 32'h001003);
        rd(8'h0c, 32'hffc013);
        rd(8'h10, 32'h0);
        rd(8'h00, 32'h0d0e);
        rd(8'h04, 32'h2);
        chk(end_irq, 1);
        wbx(1'b1, 8'h04, 32'h2);
    endtask
    task automatic burst_word;
        int g0 = dfa_bus_model_i.gcnt;
        lat <= 4'h0;
        wbx(1'b1, 8'h08, 32'h000200);
        wbx(1'b1, 8'h0c, 32'h000400);
        wbx(1'b1, 8'h10, 32'h2);
        wbx(1'b1, 8'h00, 32'h1f4d);
        wait_wr(dfa_bus_model_i.wcnt + 2);
        chk(dfa_bus_model_i.gcnt - g0, 1);
        chk(dfa_bus_model_i.last_wa, 32'h0003fe);
        chk(dfa_bus_model_i.last_wd, 32'h5858);
        rd(8'h08, 32'h000204);
        rd(8'h0c, 32'h0003fc);
        rd(8'h00, 32'h1f4c);
    endtask
    task automatic block_one(input logic [31:0] bc, input logic [31:0] ct, input logic nm);
        int w0 = dfa_bus_model_i.wcnt;
        @(posedge core_clk);
        tx <= 1'b1;
        @(posedge core_clk);
        tx <= 1'b0;
        // nmi lands inside the running block, which must still finish
        if (nm) begin
            wait_wr(w0 + 1);
            nmi <= 1'b1;
            @(posedge core_clk);
            nmi <= 1'b0;
        end
        wait_wr(w0 + 2);
        rd(8'h0c, 32'h000800);
        rd(8'h14, 32'h0202);
        rd(8'h18, bc);
        rd(8'h00, ct);
        chk(dfa_bus_model_i.wcnt - w0, 2);
    endtask
    task automatic block_mode;
        lat <= 4'h1;
        wbx(1'b1, 8'h08, 32'h000100);
        wbx(1'b1, 8'h0c, 32'h000800);
        wbx(1'b1, 8'h14, 32'h0202);
        wbx(1'b1, 8'h18, 32'h2);
        wbx(1'b1, 8'h00, 32'h1055d);
        block_one(32'h1, 32'h1055d, 1'b0);
        block_one(32'h0, 32'h10558, 1'b1);
        rd(8'h08, 32'h000108);
        chk(dfa_bus_model_i.last_wd, 32'h5b5c);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        regs_check;
        normal_steal;
        burst_word;
        block_mode;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        conclude;
    end
endmodule
bind dfa_engine dfa_engine_sva #(.INT_BASE(INT_BASE)) dfa_engine_sva_i (.core_clk, .rst_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .bus_req, .bus_gnt, .acc_o, .acc_ack,
    .end_irq);
